// [verilog/burst_params.svh]
`ifndef BURST_PARAMS_SVH
`define BURST_PARAMS_SVH
`define BP_LINE_COUNT     8
`define BP_SEL_W          3
`define COUNT_W           16
`define COUNT_MIN         16'h0001
`define COUNT_MAX         16'hc350
`define RATE_W            32
`define CLK_HZ            50000000
`define RATE_DEFAULT_HZ   100
`define SYNC_STAGES       3
`endif

// [verilog/burst_pkg.sv]
package burst_pkg;
    typedef enum logic [2:0] {
        TRIG_TIMER,
        TRIG_FRONT,
        TRIG_BUS,
        TRIG_BACKPLANE,
        TRIG_INSTANT
    } trig_src_t;

    typedef enum logic [2:0] {
        MOD_NONE,
        MOD_AM,
        MOD_FM,
        MOD_FSK,
        MOD_BURST
    } mod_t;

    typedef enum logic {
        MODE_COUNTED,
        MODE_GATED
    } burst_mode_t;
endpackage : burst_pkg

// [verilog/pin_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int W = 9);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface : pin_sync_if
`default_nettype wire

// [verilog/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 9
) (
    input  wire logic  i_core_clk,
    input  wire logic  i_rst,
    pin_sync_if.filt   pins
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // a change counts only once the second and third stages agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= pins.raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign pins.clean = out_q;
endmodule : pin_sync
`default_nettype wire

// [verilog/waveform_burst_controller.sv]
`timescale 1ns/1ns
`default_nettype none
`include "burst_params.svh"
module waveform_burst_controller #(
    parameter int unsigned DEFAULT_PERIOD = `CLK_HZ / `RATE_DEFAULT_HZ
) (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_burst_enable_cmd,
    input  wire logic                         i_mod_request_valid,
    input  wire burst_pkg::mod_t              i_mod_request,
    input  wire burst_pkg::burst_mode_t       i_burst_mode_select,
    input  wire burst_pkg::trig_src_t         i_trigger_origin_select,
    input  wire logic [`BP_SEL_W-1:0]         i_backplane_line_sel,
    input  wire logic [`COUNT_W-1:0]          i_burst_cycle_count,
    input  wire logic                         i_burst_count_infinite,
    input  wire logic [`RATE_W-1:0]           i_burst_repeat_period,
    input  wire logic                         i_bus_trigger,
    input  wire logic                         i_wave_cycle_end,
    input  wire logic                         i_front_trigger_gate_input,
    input  wire logic [`BP_LINE_COUNT-1:0]    i_backplane_trigger_line,
    output logic                              o_wave_enable,
    output logic                              o_hold_offset,
    output logic                              o_sync,
    output logic                              o_burst_active,
    output burst_pkg::mod_t                   o_active_modulation,
    output burst_pkg::trig_src_t              o_effective_trigger
);
    import burst_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pin_sync_if #(.W(`BP_LINE_COUNT + 1)) pins ();
    assign pins.raw = {i_backplane_trigger_line, i_front_trigger_gate_input};

    pin_sync #(.W(`BP_LINE_COUNT + 1)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .pins       (pins)
    );

    logic                     front_lvl;
    logic [`BP_LINE_COUNT-1:0] bp_lvl;
    assign front_lvl = pins.clean[0];
    assign bp_lvl    = pins.clean[`BP_LINE_COUNT:1];

    // ----------------------------------------
    // modulation ownership
    // ----------------------------------------
    mod_t active_q, active_d;
    logic en_prev_q, en_prev_d;
    logic burst_on;

    always_comb begin
        active_d  = active_q;
        en_prev_d = i_burst_enable_cmd;
        if (i_burst_enable_cmd && !en_prev_q) begin
            active_d = MOD_BURST;
        end else if (!i_burst_enable_cmd && en_prev_q && active_q == MOD_BURST) begin
            active_d = MOD_NONE;
        end else if (i_mod_request_valid) begin
            active_d = i_mod_request;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            active_q  <= MOD_NONE;
            en_prev_q <= 1'b0;
        end else begin
            active_q  <= active_d;
            en_prev_q <= en_prev_d;
        end
    end

    assign burst_on            = (active_q == MOD_BURST);
    assign o_active_modulation = active_q;

    // ----------------------------------------
    // trigger source resolution
    // ----------------------------------------
    trig_src_t eff_src;
    logic      gated;
    logic      sel_lvl;

    assign gated = (i_burst_mode_select == MODE_GATED);

    always_comb begin
        eff_src = i_trigger_origin_select;
        if (gated) begin
            if (i_trigger_origin_select != TRIG_BACKPLANE) begin
                eff_src = TRIG_FRONT;
            end
        end else if (i_trigger_origin_select == TRIG_INSTANT) begin
            eff_src = TRIG_FRONT;
        end
    end

    assign o_effective_trigger = eff_src;
    // any of the eight lines, chosen by index
    assign sel_lvl = (eff_src == TRIG_BACKPLANE) ? bp_lvl[i_backplane_line_sel] : front_lvl;

    // ----------------------------------------
    // internal trigger timer
    // ----------------------------------------
    logic [`RATE_W-1:0] period;
    logic [`RATE_W-1:0] tmr_q, tmr_d;
    logic               tmr_fire;
    logic               tmr_run;

    // zero period falls back to the power-on rate
    assign period   = (i_burst_repeat_period == '0) ? `RATE_W'(DEFAULT_PERIOD) : i_burst_repeat_period;
    assign tmr_run  = burst_on && !gated && (eff_src == TRIG_TIMER);
    assign tmr_fire = tmr_run && (tmr_q >= period - `RATE_W'(1));

    always_comb begin
        tmr_d = tmr_q + `RATE_W'(1);
        if (!tmr_run || tmr_fire) begin
            tmr_d = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // ----------------------------------------
    // counted burst engine
    // ----------------------------------------
    logic [`COUNT_W-1:0] target;
    logic [`COUNT_W-1:0] cnt_q, cnt_d;
    logic                run_q, run_d;
    logic                lvl_prev_q, lvl_prev_d;
    logic                trig;

    // out-of-range counts clamp into 1..50000
    always_comb begin
        target = i_burst_cycle_count;
        if (target < `COUNT_MIN) begin
            target = `COUNT_MIN;
        end else if (target > `COUNT_MAX) begin
            target = `COUNT_MAX;
        end
    end

    always_comb begin
        trig = 1'b0;
        case (eff_src)
            TRIG_TIMER:     trig = tmr_fire;
            TRIG_BUS:       trig = i_bus_trigger;
            TRIG_FRONT,
            TRIG_BACKPLANE: trig = sel_lvl && !lvl_prev_q;
            default:        trig = 1'b0;
        endcase
    end

    always_comb begin
        cnt_d      = cnt_q;
        run_d      = run_q;
        lvl_prev_d = sel_lvl;
        if (!burst_on || gated) begin
            run_d = 1'b0;
            cnt_d = '0;
        end else if (!run_q) begin
            if (trig) begin
                run_d = 1'b1;
                cnt_d = '0;
            end
        end else if (i_wave_cycle_end) begin
            // triggers during a burst are dropped, not queued
            if (!i_burst_count_infinite && (cnt_q + `COUNT_W'(1) >= target)) begin
                run_d = 1'b0;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + `COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_q      <= '0;
            run_q      <= 1'b0;
            lvl_prev_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            run_q      <= run_d;
            lvl_prev_q <= lvl_prev_d;
        end
    end

    // ----------------------------------------
    // output gating
    // ----------------------------------------
    logic wave_d, wave_q, sync_d, sync_q;

    always_comb begin
        if (!burst_on) begin
            wave_d = 1'b1;
            sync_d = 1'b1;
        end else if (gated) begin
            wave_d = sel_lvl;
            sync_d = 1'b1;
        end else begin
            wave_d = run_d;
            sync_d = !run_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wave_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            wave_q <= wave_d;
            sync_q <= sync_d;
        end
    end

    assign o_wave_enable  = wave_q;
    assign o_hold_offset  = !wave_q;
    assign o_sync         = sync_q;
    assign o_burst_active = burst_on && wave_q;
endmodule : waveform_burst_controller
`default_nettype wire

// [tb/synth_model.sv]
`timescale 1ns/1ns
`default_nettype none
module synth_model (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_wave_enable,
    output logic      o_wave_cycle_end
);
    logic [1:0] ph_q;
    logic [1:0] ph_d;
    // four clocks per waveform cycle keeps bursts short
    always_comb begin
        ph_d = i_wave_enable ? ph_q + 2'h1 : 2'h0;
    end
    always_ff @(posedge i_core_clk) begin
        ph_q <= i_rst ? 2'h0 : ph_d;
    end
    assign o_wave_cycle_end = i_wave_enable && ph_q == 2'h3;
endmodule : synth_model
`default_nettype wire

// [tb/wbc_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module wbc_sva
    import burst_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_burst_enable_cmd,
    input wire burst_mode_t i_burst_mode_select,
    input wire trig_src_t   i_trigger_origin_select,
    input wire logic        i_bus_trigger,
    input wire logic        i_wave_cycle_end,
    input wire logic        i_front_trigger_gate_input,
    input wire logic [15:0] i_burst_cycle_count,
    input wire logic        i_burst_count_infinite,
    input wire logic        o_wave_enable,
    input wire logic        o_hold_offset,
    input wire logic        o_sync,
    input wire logic        o_burst_active,
    input wire mod_t        o_active_modulation
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire own = i_burst_enable_cmd && o_active_modulation == MOD_BURST;
    wire cnt = own && i_burst_mode_select == MODE_COUNTED;
    // every non-backplane choice gates from the front pin
    wire gfr = own && i_burst_mode_select == MODE_GATED && i_trigger_origin_select != TRIG_BACKPLANE;
    sequence s_gate_hi; (gfr && i_front_trigger_gate_input)[*6]; endsequence
    sequence s_gate_lo; (gfr && !i_front_trigger_gate_input)[*6]; endsequence
    chk_hold_inverse: assert property (o_hold_offset == !o_wave_enable)
        else $error("hold offset not inverse of wave enable");
    chk_sync_wave: assert property (!o_sync |-> o_wave_enable)
        else $error("sync low without waveform");
    chk_active_own: assert property (o_burst_active == (o_active_modulation == MOD_BURST && o_wave_enable))
        else $error("burst active flag wrong");
    chk_enable_claim: assert property ($rose(i_burst_enable_cmd) |=> o_active_modulation == MOD_BURST)
        else $error("burst enable did not claim modulation");
    chk_bus_start: assert property (cnt && i_trigger_origin_select == TRIG_BUS && o_sync && !o_wave_enable
        && i_bus_trigger |=> !o_sync && o_wave_enable)
        else $error("bus trigger did not start burst");
    chk_count_end: assert property (cnt && !o_sync && !i_burst_count_infinite && i_burst_cycle_count == 16'h0001
        && i_wave_cycle_end |=> o_sync && !o_wave_enable)
        else $error("single cycle burst did not end");
    chk_gate_open: assert property (s_gate_hi |-> o_wave_enable)
        else $error("gate high without waveform");
    chk_gate_shut: assert property (s_gate_lo |-> o_hold_offset)
        else $error("gate low without offset hold");
    chk_idle_carrier: assert property ((o_active_modulation != MOD_BURST)[*2] |-> o_wave_enable && o_sync)
        else $error("carrier not continuous without burst");
endmodule : wbc_sva
bind waveform_burst_controller wbc_sva chk_u (.i_core_clk, .i_rst, .i_burst_enable_cmd, .i_burst_mode_select,
    .i_trigger_origin_select, .i_bus_trigger, .i_wave_cycle_end, .i_front_trigger_gate_input,
    .i_burst_cycle_count, .i_burst_count_infinite, .o_wave_enable, .o_hold_offset, .o_sync,
    .o_burst_active, .o_active_modulation);
`default_nettype wire

// [tb/waveform_burst_controller_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin checks_done++; if ((g)!==(e)) begin fails++; $display("MISMATCH %s exp %0h got %0h",n,e,g); end end
module waveform_burst_controller_tb;
    import burst_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, mrv = 1'b0, inf = 1'b0, bus = 1'b0, front = 1'b0, cend;
    mod_t mreq = MOD_NONE;
    burst_mode_t mode = MODE_COUNTED;
    trig_src_t org = TRIG_TIMER;
    logic [2:0] lsel = 3'h0;
    logic [15:0] cnt = 16'h0001;
    logic [31:0] per = 32'h0000000a;
    logic [7:0] bp = 8'h00;
    logic we, ho, sy, ba;
    mod_t am;
    trig_src_t et;
    int fails = 0, checks_done = 0, seed = 32'h9e0f, n, t, k;
    always #10 clk = ~clk;
    // short fallback period keeps the zero-rate case cheap to reach
    localparam int DEF_PER = 20;
    waveform_burst_controller #(.DEFAULT_PERIOD(DEF_PER)) dut_u (.i_core_clk(clk), .i_rst(rst),
        .i_burst_enable_cmd(en), .i_mod_request_valid(mrv), .i_mod_request(mreq), .i_burst_mode_select(mode),
        .i_trigger_origin_select(org), .i_backplane_line_sel(lsel), .i_burst_cycle_count(cnt),
        .i_burst_count_infinite(inf), .i_burst_repeat_period(per), .i_bus_trigger(bus), .i_wave_cycle_end(cend),
        .i_front_trigger_gate_input(front), .i_backplane_trigger_line(bp), .o_wave_enable(we), .o_hold_offset(ho),
        .o_sync(sy), .o_burst_active(ba), .o_active_modulation(am), .o_effective_trigger(et));
    synth_model sm_u (.i_core_clk(clk), .i_rst(rst), .i_wave_enable(we), .o_wave_cycle_end(cend));
    function automatic trig_src_t exp_trig(burst_mode_t m, trig_src_t s);
        if (m == MODE_GATED) return (s == TRIG_BACKPLANE) ? s : TRIG_FRONT;
        return (s == TRIG_INSTANT) ? TRIG_FRONT : s;
    endfunction : exp_trig
    task automatic wait_we(input logic v);
        for (t = 0; t < 60 && we !== v; t++) @(negedge clk);
    endtask : wait_we
    task automatic pulse_bus;
        @(negedge clk) bus = 1'b1;
        @(negedge clk) bus = 1'b0;
    endtask : pulse_bus
    task summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        #400000;
        fails++;
        summarize;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        `CHK("wave_rst", 1'b1, we)
        `CHK("mod_rst", MOD_NONE, am)
        for (n = 0; n < 10; n++) begin
            @(negedge clk);
            mode = burst_mode_t'(n / 5);
            org = trig_src_t'(n % 5);
            #1 `CHK("eff_trig", exp_trig(mode, org), et)
        end
        @(negedge clk);
        mode = MODE_COUNTED;
        org = TRIG_BUS;
        pulse_bus;
        @(negedge clk) `CHK("wave_no_burst", 1'b1, we)
        mreq = MOD_AM;
        mrv = 1'b1;
        @(negedge clk) `CHK("mod_req", MOD_AM, am)
        mrv = 1'b0;
        en = 1'b1;
        @(negedge clk) `CHK("mod_claim", MOD_BURST, am)
        for (n = 0; n < 6; n++) begin
            cnt = (n == 0) ? 16'h0000 : 16'(($random(seed) & 3) + 1);
            pulse_bus;
            `CHK("burst_start", 1'b0, sy)
            k = 0;
            for (t = 0; t < 100 && we; t++) begin
                k += cend;
                @(negedge clk);
            end
            `CHK("burst_len", (cnt == 0) ? 1 : int'(cnt), k)
            `CHK("sync_idle", 1'b1, sy)
        end
        inf = 1'b1;
        pulse_bus;
        repeat (30) @(negedge clk);
        `CHK("infinite", 1'b1, we)
        `CHK("burst_active", 1'b1, ba)
        inf = 1'b0;
        en = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("burst_idle", 1'b0, ba)
        cnt = 16'h0001;
        org = TRIG_TIMER;
        en = 1'b1;
        // carrier is still on when enabled; wait for the idle gap, then the first timed burst
        wait_we(1'b0);
        wait_we(1'b1);
        for (k = 0; k < 60 && we; k++) @(negedge clk);
        for (; k < 60 && !we; k++) @(negedge clk);
        `CHK("timer_gap", int'(per), k)
        per = 32'h00000000;
        for (k = 0; k < 60 && we; k++) @(negedge clk);
        for (; k < 60 && !we; k++) @(negedge clk);
        `CHK("timer_default", DEF_PER, k)
        wait_we(1'b0);
        org = TRIG_FRONT;
        front = 1'b1;
        wait_we(1'b1);
        `CHK("front_edge", 1'b1, we)
        wait_we(1'b0);
        front = 1'b0;
        mode = MODE_GATED;
        org = TRIG_BUS;
        repeat (6) @(negedge clk);
        `CHK("gate_low", 1'b1, ho)
        front = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("gate_high", 1'b1, we)
        front = 1'b0;
        org = TRIG_BACKPLANE;
        for (n = 0; n < 4; n++) begin
            lsel = 3'($random(seed));
            bp = 8'h01 << lsel;
            repeat (6) @(negedge clk);
            `CHK("line_true", 1'b1, we)
            bp = ~(8'h01 << lsel);
            repeat (6) @(negedge clk);
            `CHK("line_false", 1'b1, ho)
        end
        summarize;
    end
endmodule : waveform_burst_controller_tb
`default_nettype wire
